//--- logic/ebac_cfg.svh
// Constants for the byte-wide non-volatile memory access controller
// Overview of operation
// R1 - Address register holds a 6-bit byte address; bits above it read zero.
// R2 - Data register is 8 bits, read/write, zero after power-on.
// R3 - Control bits: program_enable 3, write trigger 2, fetch_enable 1, read trigger 0.
// R4 - No memory write is performed while program_enable is zero.
// R5 - Write trigger starts a write; hardware clears it when the write ends.
// R6 - Write trigger is ignored unless program_enable was already set.
// R7 - No memory read is performed while fetch_enable is zero.
// R8 - Read trigger starts a read; hardware clears it when the read ends.
// R9 - Read trigger is ignored unless fetch_enable was already set.
// R10 - Fetched byte lands in the data register and stays until the next operation.
// R11 - Software never sets both triggers, nor an enable and trigger together.
// R12 - Read: set fetch_enable, load address, set trigger, poll, then read data.
// R13 - Write: set program_enable, load address and data, trigger, poll or await irq.
// R14 - Write duration comes from a timer asynchronous to the system clock.
// R15 - Power-on clears program_enable so no write can happen.
// R16 - Write completion sets the write-done request flag.
// R17 - Request reaches the CPU only with both enables set and stack not full.
// R18 - Servicing the interrupt clears the write-done flag automatically.
// R19 - Software sets the write trigger right after setting program_enable.
// R20 - Software masks global interrupts around the start of a write.
// R21 - Control register sits at 40H in bank 1; software selects bank 01H first.
// R22 - Address and data are captured at cycle start against later changes.
`ifndef EBAC_CFG_SVH
`define EBAC_CFG_SVH
`define EBAC_CTRL_OFS 8'h40
`define EBAC_CTRL_BANK 1'b1
`define EBAC_ADDR_OFS 8'h1e
`define EBAC_BYTE_OFS 8'h1f
`define EBAC_DATA_BANK 1'b0
`define EBAC_PROGRAM_ENABLE_BIT 3
`define EBAC_WRGO_BIT 2
`define EBAC_FETCH_ENABLE_BIT 1
`define EBAC_RDGO_BIT 0
`define EBAC_ADDR_W 6
`define EBAC_BYTE_RST 8'h00
`define EBAC_CTRL_RST 4'h0
`define EBAC_READ_CYC 2
`define EBAC_WR_TICKS 16
`endif

//--- logic/ebac_ctrl.sv
// Byte access controller for the on-chip non-volatile data memory
`timescale 1ns/1ns
`include "ebac_cfg.svh"
module ebac_ctrl import ebac_pkg::*; #(
  parameter int ADDR_W = `EBAC_ADDR_W,
  parameter int WR_TICKS = `EBAC_WR_TICKS
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input ebac_sfr_req_s i_sfr,
  output logic [7:0] o_rdata,
  input wire logic i_timer_osc,
  input wire logic i_global_irq_enable,
  input wire logic i_done_irq_enable,
  input wire logic i_stack_full,
  input wire logic i_irq_ack,
  output logic o_done_flag,
  output logic o_irq_req,
  output logic o_busy
);
  localparam int DEPTH = 1 << ADDR_W;
  localparam int RC = `EBAC_READ_CYC;

  generate
    if (ADDR_W < 6 || ADDR_W > 7) begin : g_chk_addr
      $error("ebac_ctrl: ADDR_W must be 6 or 7");
    end
    if (RC < 1 || RC > 4) begin : g_chk_rd
      $error("ebac_ctrl: read cycle count must be 1 to 4");
    end
  endgenerate

  ebac_state_e state_r;
  ebac_state_e state_nxt;
  ebac_ctrl_s ctrl_r;
  logic wr_en_r;
  logic wr_go_r;
  logic rd_en_r;
  logic rd_go_r;
  logic [ADDR_W-1:0] addr_r;
  logic [7:0] byte_r;
  logic [ADDR_W-1:0] cyc_addr_r;
  logic [7:0] cyc_data_r;
  logic [1:0] rd_cnt_r;
  logic [7:0] mem_r [DEPTH];
  logic [7:0] rd_word;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic flag_r;
  logic sel_addr;
  logic sel_byte;
  logic sel_ctrl;
  logic wr_ctrl;
  logic wr_trig;
  logic rd_trig;
  logic start_wr;
  logic start_rd;
  logic rd_done;
  logic wr_done;

  // Address decode; the control register lives only in bank 1
  assign sel_addr = (i_sfr.bank == `EBAC_DATA_BANK) && (i_sfr.addr == `EBAC_ADDR_OFS);
  assign sel_byte = (i_sfr.bank == `EBAC_DATA_BANK) && (i_sfr.addr == `EBAC_BYTE_OFS);
  assign sel_ctrl = (i_sfr.bank == `EBAC_CTRL_BANK) && (i_sfr.addr == `EBAC_CTRL_OFS); // R21
  assign wr_ctrl = i_sfr.we && sel_ctrl;

  // Both triggers in one write is treated as no trigger at all
  assign wr_trig = wr_ctrl && i_sfr.wdata[`EBAC_WRGO_BIT] && !i_sfr.wdata[`EBAC_RDGO_BIT];
  assign rd_trig = wr_ctrl && i_sfr.wdata[`EBAC_RDGO_BIT] && !i_sfr.wdata[`EBAC_WRGO_BIT];

  // Enables are judged on their stored value, so a same-write enable does not count
  assign start_wr = wr_trig && ctrl_r.wr_en && (state_r == EBAC_IDLE); // R6
  assign start_rd = rd_trig && ctrl_r.rd_en && (state_r == EBAC_IDLE); // R9

  // Each control bit has its own register; the struct is the software view
  assign ctrl_r = '{wr_en: wr_en_r, wr_go: wr_go_r, rd_en: rd_en_r, rd_go: rd_go_r};

  assign rd_done = (state_r == EBAC_READ) && (rd_cnt_r == 2'(RC - 1));
  assign rd_word = mem_r[cyc_addr_r];

  ebac_write_timer #(
    .TICKS(WR_TICKS)
  ) u_timer (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_start(start_wr),
    .i_osc(i_timer_osc),
    .o_done(wr_done)
  );

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      EBAC_IDLE: begin
        if (start_wr) begin
          state_nxt = EBAC_WRITE;
        end else if (start_rd) begin
          state_nxt = EBAC_READ;
        end
      end
      EBAC_READ: begin
        if (rd_done) begin
          state_nxt = EBAC_IDLE;
        end
      end
      EBAC_WRITE: begin
        if (wr_done) begin
          state_nxt = EBAC_IDLE;
        end
      end
      default: begin
        state_nxt = EBAC_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      state_r <= EBAC_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Read length is counted in system clocks; only writes use the slow timer
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      rd_cnt_r <= 2'h0;
    end else if (start_rd) begin
      rd_cnt_r <= 2'h0;
    end else if (state_r == EBAC_READ) begin
      rd_cnt_r <= rd_cnt_r + 2'h1;
    end
  end

  // Enable bits: plain read/write, cleared at power-on
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      wr_en_r <= 1'b0; // R15
      rd_en_r <= 1'b0;
    end else if (wr_ctrl) begin
      wr_en_r <= i_sfr.wdata[`EBAC_PROGRAM_ENABLE_BIT]; // R3
      rd_en_r <= i_sfr.wdata[`EBAC_FETCH_ENABLE_BIT]; // R3
    end
  end

  // Triggers are owned by hardware once set; software cannot abort a cycle
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      wr_go_r <= 1'b0;
    end else if (start_wr) begin
      wr_go_r <= 1'b1; // R5
    end else if (wr_done) begin
      wr_go_r <= 1'b0; // R5
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      rd_go_r <= 1'b0;
    end else if (start_rd) begin
      rd_go_r <= 1'b1; // R8
    end else if (rd_done) begin
      rd_go_r <= 1'b0; // R8
    end
  end

  // Address register has no defined power-on value; cleared for determinism
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      addr_r <= '0;
    end else if (i_sfr.we && sel_addr) begin
      addr_r <= i_sfr.wdata[ADDR_W-1:0]; // R1
    end
  end

  // Cycle operands are frozen at the start
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      cyc_addr_r <= '0;
      cyc_data_r <= `EBAC_BYTE_RST;
    end else if (start_wr || start_rd) begin
      cyc_addr_r <= addr_r; // R22
      cyc_data_r <= byte_r; // R22
    end
  end

  // Fetched byte beats a software write in the same cycle
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      byte_r <= `EBAC_BYTE_RST; // R2
    end else if (rd_done && ctrl_r.rd_en) begin
      byte_r <= rd_word; // R10 R7
    end else if (i_sfr.we && sel_byte) begin
      byte_r <= i_sfr.wdata; // R2
    end
  end

  // Cell array keeps no reset; dropping program_enable mid-cycle loses the write
  always_ff @(posedge i_clk_sys) begin
    if (wr_done && ctrl_r.wr_en) begin
      mem_r[cyc_addr_r] <= cyc_data_r; // R4
    end
  end

  // Completion beats a same-cycle acknowledge
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      flag_r <= 1'b0;
    end else if (wr_done) begin
      flag_r <= 1'b1; // R16
    end else if (i_irq_ack) begin
      flag_r <= 1'b0; // R18
    end
  end

  always_comb begin
    rdata_nxt = 8'h00;
    if (sel_addr) begin
      rdata_nxt = {{(8 - ADDR_W){1'b0}}, addr_r}; // R1
    end else if (sel_byte) begin
      rdata_nxt = byte_r;
    end else if (sel_ctrl) begin
      rdata_nxt = {4'h0, ctrl_r.wr_en, ctrl_r.wr_go, ctrl_r.rd_en, ctrl_r.rd_go}; // R3
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      rdata_r <= 8'h00;
    end else if (i_sfr.re) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign o_rdata = rdata_r;
  assign o_done_flag = flag_r;
  assign o_irq_req = flag_r && i_global_irq_enable && i_done_irq_enable && !i_stack_full; // R17
  assign o_busy = (state_r != EBAC_IDLE);

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);

  addr_hi_zero_a: assert property (i_sfr.re && sel_addr |=> o_rdata[7:ADDR_W] == '0) // R1
    else $error("address register upper bits not zero");
  ctrl_read_a: assert property (i_sfr.re && sel_ctrl // R3
    |=> o_rdata[7:4] == 4'h0 && o_rdata[2] == $past(ctrl_r.wr_go))
    else $error("control register readback wrong");
  wr_refused_a: assert property (wr_trig && !ctrl_r.wr_en && state_r == EBAC_IDLE // R6
    |=> state_r == EBAC_IDLE && !ctrl_r.wr_go)
    else $error("write started without program_enable");
  rd_refused_a: assert property (rd_trig && !ctrl_r.rd_en && state_r == EBAC_IDLE // R9
    |=> state_r == EBAC_IDLE && !ctrl_r.rd_go)
    else $error("read started without fetch_enable");
  rd_timing_a: assert property (start_rd |=> ctrl_r.rd_go [*2] ##1 !ctrl_r.rd_go) // R8
    else $error("read trigger did not clear on time");
  rd_data_a: assert property (rd_done && ctrl_r.rd_en |=> byte_r == $past(rd_word)) // R10
    else $error("fetched byte not in data register");
  wr_hold_a: assert property (state_r == EBAC_WRITE && !wr_done |=> ctrl_r.wr_go) // R5
    else $error("write trigger dropped during write");
  wr_end_a: assert property (wr_done |=> !ctrl_r.wr_go && o_done_flag) // R16
    else $error("write end did not clear trigger or set flag");
  ack_clear_a: assert property (i_irq_ack && !wr_done |=> !o_done_flag) // R18
    else $error("acknowledge did not clear done flag");
  op_hold_a: assert property (state_r != EBAC_IDLE && $past(state_r) == state_r // R22
    |-> $stable(cyc_addr_r) && $stable(cyc_data_r))
    else $error("cycle operands changed mid-cycle");
  no_write_a: assert property (wr_done && !ctrl_r.wr_en |=> rd_word == $past(rd_word)) // R4
    else $error("memory changed without program_enable");

  // Reset values, decode, operand capture and completion
  reset_clear_a: assert property ($past(i_rst_n) == 1'b0 // R15 R2
    |-> ctrl_r == `EBAC_CTRL_RST && byte_r == `EBAC_BYTE_RST && !o_done_flag && !o_busy)
    else $error("state not cleared by reset");
  ctrl_bank_a: assert property (i_sfr.we && i_sfr.bank != `EBAC_CTRL_BANK // R21
    |=> $stable(wr_en_r) && $stable(rd_en_r))
    else $error("control register written outside its bank");
  op_capture_a: assert property (start_wr || start_rd // R22
    |=> cyc_addr_r == $past(addr_r) && cyc_data_r == $past(byte_r))
    else $error("cycle operands not captured at start");
  mem_write_a: assert property (wr_done && ctrl_r.wr_en |=> rd_word == $past(cyc_data_r)) // R5
    else $error("captured byte not stored");
  byte_hold_a: assert property (!(rd_done && ctrl_r.rd_en) && !(i_sfr.we && sel_byte) // R10 R7
    |=> $stable(byte_r))
    else $error("data register changed without an operation");
  flag_hold_a: assert property (o_done_flag && !i_irq_ack |=> o_done_flag) // R16
    else $error("done flag dropped without acknowledge");
  busy_read_a: assert property (start_rd |=> o_busy [*2] ##1 !o_busy) // R8
    else $error("read cycle length wrong");
  irq_gate_a: assert property (i_stack_full || !i_global_irq_enable || !i_done_irq_enable // R17
    |-> !o_irq_req)
    else $error("interrupt request while masked");
  wr_start_a: assert property (wr_trig && ctrl_r.wr_en && !o_busy // R5
    |=> o_busy && ctrl_r.wr_go)
    else $error("enabled write trigger did not start a cycle");
  rd_start_a: assert property (rd_trig && ctrl_r.rd_en && !o_busy // R8
    |=> o_busy && ctrl_r.rd_go)
    else $error("enabled read trigger did not start a cycle");

  read_done_c: cover property (start_rd ##[1:4] rd_done);
  write_done_c: cover property (start_wr ##[1:1000] wr_done);
  irq_req_c: cover property (wr_done ##1 o_irq_req);
  refused_wr_c: cover property (wr_trig && !ctrl_r.wr_en);
  refused_rd_c: cover property (rd_trig && !ctrl_r.rd_en);
endmodule // ebac_ctrl

//--- logic/ebac_pkg.sv
// Types shared by the access controller files
package ebac_pkg;
  typedef enum logic [1:0] {
    EBAC_IDLE,
    EBAC_READ,
    EBAC_WRITE
  } ebac_state_e;

  typedef struct packed {
    logic bank;
    logic [7:0] addr;
    logic we;
    logic re;
    logic [7:0] wdata;
  } ebac_sfr_req_s;

  typedef struct packed {
    logic wr_en;
    logic wr_go;
    logic rd_en;
    logic rd_go;
  } ebac_ctrl_s;
endpackage

//--- logic/ebac_write_timer.sv
// Write-cycle timer paced by an oscillator outside the system clock domain
`timescale 1ns/1ns
`include "ebac_cfg.svh"
module ebac_write_timer import ebac_pkg::*; #(
  parameter int TICKS = `EBAC_WR_TICKS
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire logic i_osc,
  output logic o_done
);
  localparam int CW = $clog2(TICKS + 1);

  generate
    if (TICKS < 1 || TICKS > 65535) begin : g_chk
      $error("ebac_write_timer: TICKS out of range");
    end
  endgenerate

  logic sync1_r;
  logic sync2_r;
  logic sync3_r;
  logic lvl_r;
  logic run_r;
  logic [CW-1:0] cnt_r;
  logic tick;

  // Oscillator level is trusted only once the last two stages agree
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
    end else begin
      sync1_r <= i_osc;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      lvl_r <= 1'b0;
    end else if (sync2_r == sync3_r) begin
      lvl_r <= sync3_r;
    end
  end

  assign tick = (sync2_r == sync3_r) && sync3_r && !lvl_r;

  // Duration depends on the free oscillator, not on system cycles
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      run_r <= 1'b0;
      cnt_r <= '0;
    end else if (i_start) begin
      run_r <= 1'b1;
      cnt_r <= '0;
    end else if (run_r && tick) begin
      if (cnt_r == CW'(TICKS - 1)) begin
        run_r <= 1'b0;
      end
      cnt_r <= cnt_r + CW'(1);
    end
  end

  assign o_done = run_r && tick && (cnt_r == CW'(TICKS - 1)); // R14

  one_tick_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // R14
    tick |=> !tick)
    else $error("oscillator rise counted twice");
  stop_after_done_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // R14
    o_done && !i_start |=> !run_r)
    else $error("timer still running after done");
endmodule // ebac_write_timer

//--- verif/tb_eeprom_byte_access_ctrl.sv
// Self-checking bench for the non-volatile memory byte access controller
`timescale 1ns/1ns
`include "ebac_cfg.svh"
`define chk(got, exp) begin compares++; if ((got) !== (exp)) begin n_errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module tb_eeprom_byte_access_ctrl;
  import ebac_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic osc = 1'b0;
  ebac_sfr_req_s sfr = '0;
  logic gie = 1'b0;
  logic die = 1'b0;
  logic stack_full = 1'b0;
  logic ack = 1'b0;
  logic [7:0] rdata;
  logic flag;
  logic irq;
  logic busy;
  logic re_d = 1'b0;
  logic [7:0] exp_q[$];
  logic [7:0] e_now;
  logic [7:0] a;
  logic [7:0] d;
  int n_errors = 0;
  int compares = 0;
  int seed_ret;

  ebac_ctrl #(.ADDR_W(6), .WR_TICKS(2)) DUT (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_sfr(sfr), .o_rdata(rdata),
    .i_timer_osc(osc), .i_global_irq_enable(gie), .i_done_irq_enable(die),
    .i_stack_full(stack_full), .i_irq_ack(ack), .o_done_flag(flag),
    .o_irq_req(irq), .o_busy(busy)
  );

  initial begin
    forever #20 clk = ~clk;
  end

  // Write-timer oscillator, unrelated in phase to the system clock
  initial begin
    forever #97 osc = ~osc;
  end

  // Read data appears on the same edge that takes the strobe, one cycle after it is driven
  always @(posedge clk) re_d <= sfr.re;
  always @(negedge clk) begin
    if (re_d && exp_q.size() > 0) begin
      e_now = exp_q.pop_front();
      `chk(rdata, e_now)
    end
  end

  task automatic summarize();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic wr(input logic bank, input logic [7:0] adr, input logic [7:0] dat);
    @(posedge clk);
    sfr <= '{bank: bank, addr: adr, we: 1'b1, re: 1'b0, wdata: dat};
    @(posedge clk);
    sfr.we <= 1'b0;
  endtask

  task automatic rd(input logic bank, input logic [7:0] adr, input logic [7:0] e);
    @(posedge clk);
    sfr <= '{bank: bank, addr: adr, we: 1'b0, re: 1'b1, wdata: 8'h00};
    exp_q.push_back(e);
    @(posedge clk);
    sfr.re <= 1'b0;
  endtask

  // Control write, then check whether a cycle was started
  task automatic go(input logic [7:0] v, input logic start);
    wr(`EBAC_CTRL_BANK, `EBAC_CTRL_OFS, v);
    @(posedge clk);
    #1;
    `chk(busy, start)
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 400) begin
      n_errors++;
      summarize();
    end
  endtask

  initial begin
    seed_ret = $urandom(32'h0000_f18d);
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd(`EBAC_DATA_BANK, `EBAC_ADDR_OFS, 8'h00);
    rd(`EBAC_DATA_BANK, `EBAC_BYTE_OFS, 8'h00);
    rd(`EBAC_CTRL_BANK, `EBAC_CTRL_OFS, 8'h00);
    wr(`EBAC_DATA_BANK, `EBAC_ADDR_OFS, 8'hff);
    rd(`EBAC_DATA_BANK, `EBAC_ADDR_OFS, 8'h3f);
    go(8'h04, 1'b0);
    rd(`EBAC_CTRL_BANK, `EBAC_CTRL_OFS, 8'h00);
    go(8'h01, 1'b0);
    rd(`EBAC_CTRL_BANK, `EBAC_CTRL_OFS, 8'h00);
    gie <= 1'b1;
    die <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      a = 8'($urandom % 64);
      d = 8'($urandom);
      wr(`EBAC_DATA_BANK, `EBAC_ADDR_OFS, a);
      wr(`EBAC_DATA_BANK, `EBAC_BYTE_OFS, d);
      gie <= 1'b0;
      wr(`EBAC_CTRL_BANK, `EBAC_CTRL_OFS, 8'h08);
      go(8'h0c, 1'b1);
      gie <= 1'b1;
      // Tamper with the data mid-cycle: the captured byte must win
      wr(`EBAC_DATA_BANK, `EBAC_BYTE_OFS, ~d);
      wait_idle();
      `chk(flag, 1'b1)
      `chk(irq, 1'b1)
      @(posedge clk);
      stack_full <= 1'b1;
      @(posedge clk);
      #1;
      `chk(irq, 1'b0)
      @(posedge clk);
      stack_full <= 1'b0;
      die <= 1'b0;
      @(posedge clk);
      #1;
      `chk(irq, 1'b0)
      @(posedge clk);
      die <= 1'b1;
      ack <= 1'b1;
      @(posedge clk);
      ack <= 1'b0;
      @(posedge clk);
      #1;
      `chk(flag, 1'b0)
      rd(`EBAC_CTRL_BANK, `EBAC_CTRL_OFS, 8'h08);
      wr(`EBAC_CTRL_BANK, `EBAC_CTRL_OFS, 8'h02);
      go(8'h03, 1'b1);
      wait_idle();
      rd(`EBAC_CTRL_BANK, `EBAC_CTRL_OFS, 8'h02);
      rd(`EBAC_DATA_BANK, `EBAC_BYTE_OFS, d);
      wr(`EBAC_CTRL_BANK, `EBAC_CTRL_OFS, 8'h00);
    end
    // Dropping the enable mid-write must leave the stored byte intact
    wr(`EBAC_CTRL_BANK, `EBAC_CTRL_OFS, 8'h08);
    wr(`EBAC_DATA_BANK, `EBAC_BYTE_OFS, ~d);
    go(8'h0c, 1'b1);
    wr(`EBAC_CTRL_BANK, `EBAC_CTRL_OFS, 8'h04);
    wait_idle();
    rd(`EBAC_CTRL_BANK, `EBAC_CTRL_OFS, 8'h00);
    wr(`EBAC_CTRL_BANK, `EBAC_CTRL_OFS, 8'h02);
    go(8'h03, 1'b1);
    wait_idle();
    rd(`EBAC_DATA_BANK, `EBAC_BYTE_OFS, d);
    repeat (3) @(posedge clk);
    summarize();
  end
endmodule // tb_eeprom_byte_access_ctrl
